// file: inc/rmcg_map.vh
// Constants of the remote command gate: function slots, default bit
// assignments, register byte addresses and control field positions.
// Assumes inclusion by bare name from the design files only.
`ifndef RMCG_MAP_VH
`define RMCG_MAP_VH

// Function slots of the assignment table.
`define RMCG_FN_START 4'h0
`define RMCG_FN_SEL1 4'h1
`define RMCG_FN_SEL2 4'h2
`define RMCG_FN_SEL4 4'h3
`define RMCG_FN_STOP 4'h4
`define RMCG_FN_PAUSE 4'h5
`define RMCG_FN_CONT 4'h6
`define RMCG_FN_RESET 4'h7
`define RMCG_FN_MOTON 4'h8
`define RMCG_FN_MOTOFF 4'h9
`define RMCG_FN_HOME 4'ha
`define RMCG_FN_LOWPWR 4'hb
`define RMCG_FN_COUNT 12
`define RMCG_FN_LAST 4'hb

// Table entry: bit 5 marks the slot assigned, bits 4..0 hold the input bit.
`define RMCG_ENT_USED 5
`define RMCG_ENT_NUM_MSB 4
`define RMCG_ENT_NONE 6'h00
`define RMCG_DEF_START 6'h20
`define RMCG_DEF_SEL1 6'h21
`define RMCG_DEF_SEL2 6'h22
`define RMCG_DEF_SEL4 6'h23
`define RMCG_DEF_STOP 6'h24
`define RMCG_DEF_PAUSE 6'h25
`define RMCG_DEF_CONT 6'h26
`define RMCG_DEF_RESET 6'h27

// Register byte addresses; table slots sit at 0x40 + 4 * slot.
`define RMCG_ADDR_CTRL 8'h00
`define RMCG_ADDR_VIRT 8'h04
`define RMCG_ADDR_STAT 8'h08
`define RMCG_ADDR_EFFIN 8'h0c
`define RMCG_MAP_PAGE 2'h1

// Control register fields.
`define RMCG_CTRL_ASSIGNED 0
`define RMCG_CTRL_AUTO 1
`define RMCG_CTRL_SRC_REMOTE 2
`define RMCG_CTRL_PROGRAM 3
`define RMCG_CTRL_RIO_EN 4
`define RMCG_CTRL_VIRT_EN 5
`define RMCG_CTRL_RST 6'h01

`define RMCG_RESP_OKAY 2'h0
`define RMCG_RESP_SLVERR 2'h2

`endif

// file: logic/rmcg_map_table.v
// Function-to-input-bit assignment table of the remote command gate.
// Assumes one clock, synchronous active-high reset and a single writer.
`default_nettype none
`include "rmcg_map.vh"

module rmcg_map_table (
    input wire mclk,
    input wire sys_rst,
    input wire wrEn,
    input wire [3:0] wrIdx,
    input wire [5:0] wrData,
    input wire [3:0] rdIdx,
    output reg [5:0] rdData_ff,
    output reg [71:0] tableFlat
);
    reg [5:0] entry_ff [0:11];
    // Each process has its own loop index so no variable has two writers.
    integer i;
    integer j;

    function [5:0] defaultEntry;
        input [3:0] idx;
        begin
            case (idx)
                `RMCG_FN_START: defaultEntry = `RMCG_DEF_START;
                `RMCG_FN_SEL1: defaultEntry = `RMCG_DEF_SEL1;
                `RMCG_FN_SEL2: defaultEntry = `RMCG_DEF_SEL2;
                `RMCG_FN_SEL4: defaultEntry = `RMCG_DEF_SEL4;
                `RMCG_FN_STOP: defaultEntry = `RMCG_DEF_STOP;
                `RMCG_FN_PAUSE: defaultEntry = `RMCG_DEF_PAUSE;
                `RMCG_FN_CONT: defaultEntry = `RMCG_DEF_CONT;
                `RMCG_FN_RESET: defaultEntry = `RMCG_DEF_RESET;
                default: defaultEntry = `RMCG_ENT_NONE;
            endcase
        end
    endfunction

    always @(posedge mclk) begin
        if (sys_rst) begin
            for (i = 0; i < `RMCG_FN_COUNT; i = i + 1) begin
                entry_ff[i] <= defaultEntry(i[3:0]);
            end
            rdData_ff <= `RMCG_ENT_NONE;
        end else begin
            if (wrEn && wrIdx <= `RMCG_FN_LAST) begin
                entry_ff[wrIdx] <= wrData;
            end
            if (rdIdx <= `RMCG_FN_LAST) begin
                rdData_ff <= entry_ff[rdIdx];
            end else begin
                rdData_ff <= `RMCG_ENT_NONE;
            end
        end
    end

    always @* begin
        for (j = 0; j < `RMCG_FN_COUNT; j = j + 1) begin
            tableFlat[j*6 +: 6] = entry_ff[j];
        end
    end
endmodule
`default_nettype wire

// file: logic/rmcg_gate.v
// Remote command gate: turns host input edges into one-cycle command
// pulses for the controller core, gated by the core's status levels.
// Assumes status inputs are synchronous to mclk (wired inputs pass a two-stage synchroniser) and an
// AXI4-Lite master that keeps one write and one read in flight at most.
//
// Contract
// - In teach mode all commands are ignored; status keeps updating; code still passes forced low power stop and hold.
// - Remote-accepting is on when functions assigned and source is remote.
// - Non-select commands fire on rising edge if conditions hold then.
// - After error only reset is accepted; host watches error and resets; code also passes forced low power.
// - Start launches selected program: ready, no error/stop/guard/pause.
// - Three select inputs form the program number; they trigger nothing.
// - Select bits weigh 1, 2, 4; all off picks the base program.
// - Stop halts everything; needs only remote availability; code also blocks it while error is on.
// - Pause is accepted only while running is on.
// - Continue needs paused on and pause and stop inputs off.
// - Reset clears emergency stop and error; needs ready on.
// - Motor enable needs ready, no e-stop, no guard, no disable input.
// - Motor disable removes power; needs ready on.
// - Home needs ready, motors on, no faults, pause and stop off.
// - Forced low power stops tasks and holds low power while on.
// - Forced low power is honoured even when remote-accepting is off.
// - Simulated inputs work exactly like wired inputs.
// - Every command also needs remote-accepting on; code lets forced low power bypass it.
// - Remote-accepting: auto mode with remote source, or program mode; code also needs RIO enable in program mode.
// - Forced low power falling also stops all tasks.
//
// Implementation choices: the placing of the registers and the AXI4-Lite register port.
`default_nettype none
`include "rmcg_map.vh"

module rmcg_gate (
    input wire mclk,
    input wire sys_rst,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire [31:0] wiredInputs,
    input wire readyStatus,
    input wire runningStatus,
    input wire pausedStatus,
    input wire errorStatus,
    input wire emergency_stop_status,
    input wire guard_open_status,
    input wire motor_powered_status,
    input wire teaching_status,
    output wire startPulse,
    output wire [2:0] programNumber,
    output wire stopPulse,
    output wire pausePulse,
    output wire continuePulse,
    output wire errorResetPulse,
    output wire motorOnPulse,
    output wire motorOffPulse,
    output wire homePulse,
    output wire lowPowerHold,
    output wire remote_accepting_status
);
    reg awReady_ff, wReady_ff, bValid_ff, awHeld_ff, wHeld_ff;
    reg [1:0] bResp_ff;
    reg [7:0] awAddr_ff;
    reg [31:0] wData_ff;
    reg [3:0] wStrb_ff;
    reg arReady_ff, rdStage_ff, rValid_ff;
    reg [7:0] rdAddr_ff;
    reg [31:0] rData_ff;
    reg [1:0] rResp_ff;
    reg [5:0] ctrl_ff;
    reg [31:0] virtIn_ff;
    reg [31:0] syncA_ff, syncB_ff;
    reg [11:0] prevLvl_ff;
    reg startPulse_ff, stopPulse_ff, pausePulse_ff, continuePulse_ff;
    reg errorResetPulse_ff, motorOnPulse_ff, motorOffPulse_ff;
    reg homePulse_ff, lowPowerHold_ff, remoteAccepting_ff;
    reg [2:0] programNumber_ff;
    reg [11:0] lvl;
    reg [31:0] readMux;
    wire [5:0] memRd;
    wire [71:0] tableFlat;
    wire [31:0] effIn;
    wire [11:0] rise, fall;
    wire doWrite, gateOk, cmdOk, nxt_remoteAccepting;
    wire [31:0] ctrlMerged, virtMerged;
    integer f;

    // True when the byte address is a word-aligned slot 0..11 of the assignment table page.
    function isMapAddr;
        input [7:0] addr;
        begin
            isMapAddr = (addr[7:6] == `RMCG_MAP_PAGE) &&
                (addr[5:2] <= `RMCG_FN_LAST) && (addr[1:0] == 2'h0);
        end
    endfunction

    function addrHit;
        input [7:0] addr;
        begin
            addrHit = isMapAddr(addr) || addr == `RMCG_ADDR_CTRL ||
                addr == `RMCG_ADDR_VIRT || addr == `RMCG_ADDR_STAT ||
                addr == `RMCG_ADDR_EFFIN;
        end
    endfunction

    function [31:0] applyStrb;
        input [31:0] old;
        input [31:0] nw;
        input [3:0] strb;
        integer b;
        begin
            applyStrb = old;
            for (b = 0; b < 4; b = b + 1) begin
                if (strb[b]) begin
                    applyStrb[b*8 +: 8] = nw[b*8 +: 8];
                end
            end
        end
    endfunction

    // Level of one function: its assigned input bit, or off if unassigned.
    function lvlOf;
        input [5:0] ent;
        input [31:0] ins;
        begin
            lvlOf = ent[`RMCG_ENT_USED] & ins[ent[`RMCG_ENT_NUM_MSB:0]];
        end
    endfunction

    assign s_axi_awready = awReady_ff;
    assign s_axi_wready = wReady_ff;
    assign s_axi_bvalid = bValid_ff;
    assign s_axi_bresp = bResp_ff;
    assign s_axi_arready = arReady_ff;
    assign s_axi_rvalid = rValid_ff;
    assign s_axi_rdata = rData_ff;
    assign s_axi_rresp = rResp_ff;
    assign startPulse = startPulse_ff;
    assign programNumber = programNumber_ff;
    assign stopPulse = stopPulse_ff;
    assign pausePulse = pausePulse_ff;
    assign continuePulse = continuePulse_ff;
    assign errorResetPulse = errorResetPulse_ff;
    assign motorOnPulse = motorOnPulse_ff;
    assign motorOffPulse = motorOffPulse_ff;
    assign homePulse = homePulse_ff;
    assign lowPowerHold = lowPowerHold_ff;
    assign remote_accepting_status = remoteAccepting_ff;

    assign doWrite = awHeld_ff & wHeld_ff & ~bValid_ff;
    assign ctrlMerged = applyStrb({26'h0, ctrl_ff}, wData_ff, wStrb_ff);
    assign virtMerged = applyStrb(virtIn_ff, wData_ff, wStrb_ff);

    rmcg_map_table mapTable (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .wrEn(doWrite & isMapAddr(awAddr_ff) & wStrb_ff[0]),
        .wrIdx(awAddr_ff[5:2]),
        .wrData(wData_ff[5:0]),
        .rdIdx(s_axi_araddr[5:2]),
        .rdData_ff(memRd),
        .tableFlat(tableFlat)
    );

    // Write channel: address and data are taken in either order; the
    // response is raised once both are held, and both readies stay low
    // until the response is taken so only one write is ever in flight.
    always @(posedge mclk) begin
        if (sys_rst) begin
            awReady_ff <= 1'b1;
            wReady_ff <= 1'b1;
            awHeld_ff <= 1'b0;
            wHeld_ff <= 1'b0;
            bValid_ff <= 1'b0;
            bResp_ff <= `RMCG_RESP_OKAY;
            awAddr_ff <= 8'h00;
            wData_ff <= 32'h00000000;
            wStrb_ff <= 4'h0;
        end else begin
            if (s_axi_awvalid && awReady_ff) begin
                awAddr_ff <= s_axi_awaddr;
                awHeld_ff <= 1'b1;
                awReady_ff <= 1'b0;
            end
            if (s_axi_wvalid && wReady_ff) begin
                wData_ff <= s_axi_wdata;
                wStrb_ff <= s_axi_wstrb;
                wHeld_ff <= 1'b1;
                wReady_ff <= 1'b0;
            end
            if (doWrite) begin
                awHeld_ff <= 1'b0;
                wHeld_ff <= 1'b0;
                bValid_ff <= 1'b1;
                if (addrHit(awAddr_ff)) begin
                    bResp_ff <= `RMCG_RESP_OKAY;
                end else begin
                    bResp_ff <= `RMCG_RESP_SLVERR;
                end
            end
            if (bValid_ff && s_axi_bready) begin
                bValid_ff <= 1'b0;
                awReady_ff <= 1'b1;
                wReady_ff <= 1'b1;
            end
        end
    end

    always @(posedge mclk) begin
        if (sys_rst) begin
            ctrl_ff <= `RMCG_CTRL_RST;
            virtIn_ff <= 32'h00000000;
        end else if (doWrite) begin
            if (awAddr_ff == `RMCG_ADDR_CTRL) begin
                ctrl_ff <= ctrlMerged[5:0];
            end
            if (awAddr_ff == `RMCG_ADDR_VIRT) begin
                virtIn_ff <= virtMerged;
            end
        end
    end

    always @* begin
        readMux = 32'h00000000;
        if (isMapAddr(rdAddr_ff)) begin
            readMux = {26'h0, memRd};
        end else begin
            case (rdAddr_ff)
                `RMCG_ADDR_CTRL: readMux = {26'h0, ctrl_ff};
                `RMCG_ADDR_VIRT: readMux = virtIn_ff;
                `RMCG_ADDR_STAT: readMux = {26'h0, teaching_status,
                    programNumber_ff, lowPowerHold_ff, remoteAccepting_ff};
                `RMCG_ADDR_EFFIN: readMux = effIn;
                default: readMux = 32'h00000000;
            endcase
        end
    end

    // Read channel: the table is read on the same edge that takes the
    // address, so the data valid comes one edge after the handshake.
    always @(posedge mclk) begin
        if (sys_rst) begin
            arReady_ff <= 1'b1;
            rdStage_ff <= 1'b0;
            rValid_ff <= 1'b0;
            rdAddr_ff <= 8'h00;
            rData_ff <= 32'h00000000;
            rResp_ff <= `RMCG_RESP_OKAY;
        end else begin
            if (s_axi_arvalid && arReady_ff) begin
                rdAddr_ff <= s_axi_araddr;
                arReady_ff <= 1'b0;
                rdStage_ff <= 1'b1;
            end
            if (rdStage_ff) begin
                rdStage_ff <= 1'b0;
                rValid_ff <= 1'b1;
                rData_ff <= readMux;
                if (addrHit(rdAddr_ff)) begin
                    rResp_ff <= `RMCG_RESP_OKAY;
                end else begin
                    rResp_ff <= `RMCG_RESP_SLVERR;
                end
            end
            if (rValid_ff && s_axi_rready) begin
                rValid_ff <= 1'b0;
                arReady_ff <= 1'b1;
            end
        end
    end

    // Two-stage synchroniser; the first stage feeds nothing but the second.
    always @(posedge mclk) begin
        if (sys_rst) begin
            syncA_ff <= 32'h00000000;
            syncB_ff <= 32'h00000000;
        end else begin
            syncA_ff <= wiredInputs;
            syncB_ff <= syncA_ff;
        end
    end

    assign effIn = ctrl_ff[`RMCG_CTRL_VIRT_EN] ? virtIn_ff : syncB_ff;

    always @* begin
        for (f = 0; f < `RMCG_FN_COUNT; f = f + 1) begin
            lvl[f] = lvlOf(tableFlat[f*6 +: 6], effIn);
        end
    end

    assign rise = lvl & ~prevLvl_ff;
    assign fall = ~lvl & prevLvl_ff;

    // Status is computed regardless of teach mode; only commands are gated.
    assign nxt_remoteAccepting = ctrl_ff[`RMCG_CTRL_ASSIGNED] &
        ((ctrl_ff[`RMCG_CTRL_AUTO] & ctrl_ff[`RMCG_CTRL_SRC_REMOTE]) |
        (ctrl_ff[`RMCG_CTRL_PROGRAM] & ctrl_ff[`RMCG_CTRL_RIO_EN]));
    assign gateOk = remoteAccepting_ff & ~teaching_status;
    assign cmdOk = gateOk & ~errorStatus;

    always @(posedge mclk) begin
        if (sys_rst) begin
            prevLvl_ff <= 12'h000;
            remoteAccepting_ff <= 1'b0;
            startPulse_ff <= 1'b0;
            programNumber_ff <= 3'h0;
            stopPulse_ff <= 1'b0;
            pausePulse_ff <= 1'b0;
            continuePulse_ff <= 1'b0;
            errorResetPulse_ff <= 1'b0;
            motorOnPulse_ff <= 1'b0;
            motorOffPulse_ff <= 1'b0;
            homePulse_ff <= 1'b0;
            lowPowerHold_ff <= 1'b0;
        end else begin
            prevLvl_ff <= lvl;
            remoteAccepting_ff <= nxt_remoteAccepting;
            startPulse_ff <= rise[`RMCG_FN_START] & cmdOk & readyStatus &
                ~emergency_stop_status & ~guard_open_status &
                ~lvl[`RMCG_FN_PAUSE] & ~lvl[`RMCG_FN_STOP];
            if (rise[`RMCG_FN_START] && cmdOk && readyStatus &&
                !emergency_stop_status && !guard_open_status &&
                !lvl[`RMCG_FN_PAUSE] && !lvl[`RMCG_FN_STOP]) begin
                programNumber_ff <= {lvl[`RMCG_FN_SEL4],
                    lvl[`RMCG_FN_SEL2], lvl[`RMCG_FN_SEL1]};
            end
            // Forced low power bypasses every gate and stops on both edges.
            stopPulse_ff <= (rise[`RMCG_FN_STOP] & cmdOk) |
                rise[`RMCG_FN_LOWPWR] | fall[`RMCG_FN_LOWPWR];
            pausePulse_ff <= rise[`RMCG_FN_PAUSE] & cmdOk &
                runningStatus;
            continuePulse_ff <= rise[`RMCG_FN_CONT] & cmdOk & pausedStatus &
                ~lvl[`RMCG_FN_PAUSE] & ~lvl[`RMCG_FN_STOP];
            errorResetPulse_ff <= rise[`RMCG_FN_RESET] & gateOk &
                readyStatus;
            motorOnPulse_ff <= rise[`RMCG_FN_MOTON] & cmdOk & readyStatus &
                ~emergency_stop_status & ~guard_open_status &
                ~lvl[`RMCG_FN_MOTOFF];
            motorOffPulse_ff <= rise[`RMCG_FN_MOTOFF] & cmdOk &
                readyStatus;
            homePulse_ff <= rise[`RMCG_FN_HOME] & cmdOk & readyStatus &
                motor_powered_status & ~emergency_stop_status &
                ~guard_open_status & ~lvl[`RMCG_FN_PAUSE] &
                ~lvl[`RMCG_FN_STOP];
            lowPowerHold_ff <= lvl[`RMCG_FN_LOWPWR];
        end
    end
endmodule
`default_nettype wire

// file: test/rmcg_gate_sva.sv
// Assertions on the command pulses of the remote command gate.
// Assumes it is bound to rmcg_gate and sees only that module's ports.
`default_nettype none
module rmcg_gate_sva (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic readyStatus,
    input wire logic runningStatus,
    input wire logic pausedStatus,
    input wire logic errorStatus,
    input wire logic emergency_stop_status,
    input wire logic guard_open_status,
    input wire logic motor_powered_status,
    input wire logic teaching_status,
    input wire logic startPulse,
    input wire logic [2:0] programNumber,
    input wire logic stopPulse,
    input wire logic pausePulse,
    input wire logic continuePulse,
    input wire logic errorResetPulse,
    input wire logic motorOnPulse,
    input wire logic motorOffPulse,
    input wire logic homePulse,
    input wire logic lowPowerHold,
    input wire logic remote_accepting_status
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);
    // Gate conditions are judged in the cycle of the rise, one before the pulse.
    wire okAcc = remote_accepting_status & ~teaching_status;
    wire fault = errorStatus | emergency_stop_status | guard_open_status;

    start_gate_a: assert property (
        startPulse |-> $past(okAcc & readyStatus & ~fault))
        else $error("start pulse without its conditions");
    pause_gate_a: assert property (
        pausePulse |-> $past(okAcc & runningStatus & ~errorStatus))
        else $error("pause pulse while not running");
    cont_gate_a: assert property (
        continuePulse |-> $past(okAcc & pausedStatus & ~errorStatus))
        else $error("continue pulse while not paused");
    reset_gate_a: assert property (
        errorResetPulse |-> $past(okAcc & readyStatus))
        else $error("error reset pulse while not ready");
    motor_on_gate_a: assert property (
        motorOnPulse |-> $past(okAcc & readyStatus & ~emergency_stop_status
            & ~guard_open_status))
        else $error("motor on pulse without its conditions");
    home_gate_a: assert property (
        homePulse |-> $past(okAcc & readyStatus & motor_powered_status & ~fault))
        else $error("home pulse without its conditions");
    error_block_a: assert property (
        $past(errorStatus) |-> !(startPulse | pausePulse | continuePulse
            | motorOnPulse | motorOffPulse | homePulse))
        else $error("command pulse while error is on");
    start_single_a: assert property (
        startPulse |=> !startPulse)
        else $error("start pulse longer than one cycle");
    program_load_a: assert property (
        $changed(programNumber) |-> startPulse)
        else $error("program number changed without a start");
    low_stop_a: assert property (
        $changed(lowPowerHold) |-> $past(stopPulse) or ##[0:1] stopPulse)
        else $error("low power change without stop pulse");

    cover property (startPulse && programNumber == 3'h5);
    cover property ($rose(lowPowerHold));
    cover property (errorResetPulse && $past(errorStatus));
endmodule

bind rmcg_gate rmcg_gate_sva chk (
    .mclk, .sys_rst, .readyStatus, .runningStatus, .pausedStatus,
    .errorStatus, .emergency_stop_status, .guard_open_status,
    .motor_powered_status, .teaching_status, .startPulse, .programNumber,
    .stopPulse, .pausePulse, .continuePulse, .errorResetPulse,
    .motorOnPulse, .motorOffPulse, .homePulse, .lowPowerHold,
    .remote_accepting_status
);
`default_nettype wire

// file: test/rmcg_host_model.sv
// Host model: a controller on the far side that drives remote input bits.
// Assumes the bench calls drive() right after a rising edge of mclk.
`default_nettype none
module rmcg_host_model (
    input wire logic mclk,
    input wire logic acceptOk,
    output logic [31:0] wiredInputs
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] insLevel_ff = 32'h00000000;
    assign wiredInputs = insLevel_ff;
    // A gate that never accepts only delays the host; the bench judges it.
    task automatic drive(input int b, input logic v);
        int n;
        for (n = 0; n < 20 && acceptOk !== 1'b1; n++) @(posedge mclk);
        @(posedge mclk);
        insLevel_ff[b] <= v;
    endtask
endmodule
`default_nettype wire

// file: test/rmcg_gate_tb.sv
// Self-checking bench for the remote command gate: registers over
// AXI4-Lite, command edges from the host model against status levels.
// Assumes the design files, checker and host model are compiled first.
`default_nettype none
module rmcg_gate_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 1'b0;
    logic sysRst = 1'b1;
    logic [7:0] awAddr = 8'h00, arAddr = 8'h00, st = 8'h00;
    logic awValid = 1'b0, wValid = 1'b0, arValid = 1'b0, clr = 1'b0;
    logic [31:0] wData = 32'h00000000, rd;
    logic [7:0] seen = 8'h00;
    logic [23:0] tbl [0:15];
    wire awReady, wReady, bValid, arReady, rValid, lowHold, accepting;
    wire [1:0] bResp, rResp;
    wire [31:0] rData, wired;
    wire [2:0] progNum;
    wire [7:0] pv;
    int bad_count = 0;
    int compares = 0;
    int i;

    rmcg_gate uut (.mclk(mclk), .sys_rst(sysRst),
        .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
        .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
        .s_axi_bvalid(bValid), .s_axi_bready(1'b1), .s_axi_araddr(arAddr),
        .s_axi_arvalid(arValid), .s_axi_arready(arReady),
        .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
        .s_axi_rready(1'b1), .wiredInputs(wired), .readyStatus(st[0]),
        .runningStatus(st[1]), .pausedStatus(st[2]), .errorStatus(st[3]),
        .emergency_stop_status(st[4]), .guard_open_status(st[5]),
        .motor_powered_status(st[6]), .teaching_status(st[7]),
        .startPulse(pv[0]), .programNumber(progNum), .stopPulse(pv[1]),
        .pausePulse(pv[2]), .continuePulse(pv[3]),
        .errorResetPulse(pv[4]), .motorOnPulse(pv[5]),
        .motorOffPulse(pv[6]), .homePulse(pv[7]), .lowPowerHold(lowHold),
        .remote_accepting_status(accepting));
    rmcg_host_model host (.mclk(mclk), .acceptOk(accepting | st[0]),
        .wiredInputs(wired));

    always #50 mclk = ~mclk;
    // Pulses last one cycle, so they are gathered here between checks.
    always @(posedge mclk) seen <= clr ? 8'h00 : (seen | pv);

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] s);
        compares++;
        if (s !== e) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic final_report;
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic axw(input logic [7:0] a, input logic [31:0] d,
                       input logic [1:0] er);
        int n;
        awAddr <= a;
        wData <= d;
        awValid <= 1'b1;
        wValid <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge mclk);
            if (awValid && awReady) awValid <= 1'b0;
            if (wValid && wReady) wValid <= 1'b0;
            if (bValid) break;
        end
        if (n == 50) begin
            bad_count++;
            final_report;
        end
        chk("bresp", 32'(er), 32'(bResp));
    endtask

    task automatic axr(input logic [7:0] a, input logic [1:0] er,
                       output logic [31:0] d);
        int n;
        arAddr <= a;
        arValid <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge mclk);
            if (arValid && arReady) arValid <= 1'b0;
            if (rValid) break;
        end
        if (n == 50) begin
            bad_count++;
            final_report;
        end
        d = rData;
        chk("rresp", 32'(er), 32'(rResp));
    endtask

    task automatic go(input int b, input logic v, input logic [7:0] e);
        clr <= 1'b1;
        @(posedge mclk);
        clr <= 1'b0;
        host.drive(b, v);
        repeat (7) @(posedge mclk);
        chk("pulses", 32'(e), 32'(seen));
    endtask

    initial begin
        tbl = '{24'h090000,
                24'h090710,
                24'h000700,
                24'h000402,
                24'h030504,
                24'h010500,
                24'h050608,
                24'h010600,
                24'h010820,
                24'h110800,
                24'h010940,
                24'h000900,
                24'h410a80,
                24'h010a00,
                24'h810000,
                24'h210000};
        repeat (5) @(posedge mclk);
        sysRst <= 1'b0;
        @(posedge mclk);
        axr(8'h40, 2'h0, rd);
        chk("slot0", 32'h20, rd);
        axr(8'h60, 2'h0, rd);
        chk("slot8", 32'h00, rd);
        axr(8'h80, 2'h2, rd);
        chk("unmapped", 32'h0, rd);
        axw(8'h80, 32'h1, 2'h2);
        axw(8'h00, 32'h06, 2'h0);
        axr(8'h08, 2'h0, rd);
        chk("accept", 32'h0, 32'(rd[0]));
        axw(8'h00, 32'h19, 2'h0);
        axr(8'h08, 2'h0, rd);
        chk("accept", 32'h1, 32'(rd[0]));
        axw(8'h00, 32'h07, 2'h0);
        for (i = 0; i < 4; i++)
            axw(8'(8'h60 + 4 * i), 32'(32'h28 + i), 2'h0);
        st <= 8'h01;
        go(1, 1'b1, 8'h00);
        go(3, 1'b1, 8'h00);
        go(0, 1'b1, 8'h01);
        chk("program", 32'h5, 32'(progNum));
        go(0, 1'b0, 8'h00);
        go(1, 1'b0, 8'h00);
        go(3, 1'b0, 8'h00);
        go(5, 1'b1, 8'h00);
        go(0, 1'b1, 8'h00);
        go(0, 1'b0, 8'h00);
        go(5, 1'b0, 8'h00);
        for (i = 0; i < 16; i++) begin
            st <= tbl[i][23:16];
            go(int'(tbl[i][15:8]), 1'b1, tbl[i][7:0]);
            go(int'(tbl[i][15:8]), 1'b0, 8'h00);
        end
        st <= 8'h81;
        axr(8'h08, 2'h0, rd);
        chk("teach", 32'h1, 32'(rd[5]));
        st <= 8'h01;
        axw(8'h00, 32'h01, 2'h0);
        go(0, 1'b1, 8'h00);
        go(0, 1'b0, 8'h00);
        go(11, 1'b1, 8'h02);
        chk("lowhold", 32'h1, 32'(lowHold));
        go(11, 1'b0, 8'h02);
        chk("lowhold", 32'h0, 32'(lowHold));
        axw(8'h00, 32'h27, 2'h0);
        clr <= 1'b1;
        @(posedge mclk);
        clr <= 1'b0;
        axw(8'h04, 32'h1, 2'h0);
        repeat (6) @(posedge mclk);
        chk("virtual", 32'h01, 32'(seen));
        axw(8'h04, 32'h0, 2'h0);
        final_report;
    end
endmodule
`default_nettype wire
